// File: design/pcie_ext_cfg_map.svh
/*
   Offsets, field positions and reset values of the extended configuration
   space and its error-reporting structure. Included by bare name.
*/
`ifndef PCIE_EXT_CFG_MAP_SVH
`define PCIE_EXT_CFG_MAP_SVH

// ----------------------------------------
// Configuration address fields
// ----------------------------------------
`define CFG_BUS_MSB 27
`define CFG_BUS_LSB 20
`define CFG_DEV_MSB 19
`define CFG_DEV_LSB 15
`define CFG_FN_MSB 14
`define CFG_FN_LSB 12
`define CFG_REG_MSB 11
`define CFG_REG_LSB 2

// ----------------------------------------
// Capability chain offsets
// ----------------------------------------
`define AER_HDR_OFF 12'h100
`define AER_STATUS_OFF 12'h104
`define AER_MASK_OFF 12'h108
`define AER_SEV_OFF 12'h10C
`define AER_CSTAT_OFF 12'h110
`define AER_CMASK_OFF 12'h114
`define AER_CAPCTL_OFF 12'h118
`define AER_HLOG_FIRST 12'h11C
`define AER_HLOG_LAST 12'h128
`define SERIAL_CAP_OFF 12'h140
`define HINTS_CAP_OFF 12'h1A0
`define LATENCY_CAP_OFF 12'h1C0
`define CHAIN_END_PTR 12'h000

// ----------------------------------------
// Header dword fields and reset values
// ----------------------------------------
`define HDR_ID_LSB 0
`define HDR_VER_LSB 16
`define HDR_NEXT_LSB 20
`define AER_CAP_ID 16'h0001
`define AER_VER_RST 4'h2
`define AER_UNC_IMPL 32'h001FF010
`define AER_SEV_RO 32'h00400021
`define AER_SEV_RST 32'h00062010
`define AER_FLAG_RST 32'h00000000
`define AER_MASK_RST 32'h00000000

`endif

// File: design/pcie_ext_cfg_pkg.sv
/*
   Types shared by the extended configuration register logic.
   Assumes the map header supplies all numeric constants.
*/
package pcie_ext_cfg_pkg;

   // Configuration request from the transaction layer
   typedef struct packed {
      logic valid;         // One-cycle request strobe
      logic write;         // 1 write, 0 read
      logic [31:0] addr;   // Configuration address
      logic [31:0] data;   // Write data
      logic [3:0] byteEn;  // Byte enables
   } cfg_req_type;

   // Completion back to the transaction layer
   typedef struct packed {
      logic valid;         // One-cycle completion strobe
      logic [31:0] data;   // Read data, zero for writes
   } cfg_rsp_type;

   // Own routing identity
   typedef struct packed {
      logic [7:0] bus;
      logic [4:0] dev;
      logic [2:0] fn;
   } cfg_id_type;

   // Values delivered by the on-chip non-volatile loader
   typedef struct packed {
      logic load;          // One-cycle strobe, values valid
      logic [3:0] aerVersion;
      logic serialEn;
      logic hintsEn;
      logic latencyEn;
   } nvm_cfg_type;

   // Error message requests toward the host bridge
   typedef struct packed {
      logic fatal;
      logic nonFatal;
   } err_msg_type;

endpackage

// File: design/aer_error_bit.sv
/*
   One implemented uncorrectable error type: its sticky status flag, its
   sticky mask bit and its sticky severity bit.
   Assumes rst_n is the fundamental reset only, synchronised by the parent.
*/
`timescale 1ns/10ps
`default_nettype none

module aer_error_bit #(
   parameter logic SEV_RESET = 1'b0  // Severity after fundamental reset
) (
   input wire logic clock,       // 50 MHz clock
   input wire logic rst_n,       // Fundamental reset, active low
   input wire logic errEvent,    // Error seen this cycle
   input wire logic clearStrobe, // Software writes 1 to the flag
   input wire logic maskWe,      // Mask byte written
   input wire logic sevWe,       // Severity byte written
   input wire logic wrBit,       // Write data bit
   output logic statusBit,       // Sticky flag
   output logic maskBit,         // Sticky mask
   output logic sevBit           // Sticky severity
);

   // ----------------------------------------
   // Next values
   // ----------------------------------------
   logic status_reg;
   logic mask_reg;
   logic sev_reg;
   logic status_next;
   logic mask_next;
   logic sev_next;

   // A new error outweighs a clear in the same cycle
   assign status_next = errEvent | (status_reg & ~clearStrobe);
   assign mask_next = maskWe ? wrBit : mask_reg;
   assign sev_next = sevWe ? wrBit : sev_reg;

   // ----------------------------------------
   // Sticky storage
   // ----------------------------------------
   // Only a fundamental reset reaches these flops, so hot reset keeps them
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status_reg <= 1'b0;
         mask_reg <= 1'b0;
         sev_reg <= SEV_RESET;
      end
      else
      begin
         status_reg <= status_next;
         mask_reg <= mask_next;
         sev_reg <= sev_next;
      end
   end

   assign statusBit = status_reg;
   assign maskBit = mask_reg;
   assign sevBit = sev_reg;

endmodule

`default_nettype wire

// File: design/pcie_ext_cfg_aer_uncorrectable.sv
/*
   Extended configuration space decode, capability chain and the
   uncorrectable error status, mask and severity registers.
   Assumes requests arrive as one-cycle strobes synchronous to clock, and
   that errEvent bits are one-cycle pulses from the transaction layer.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pcie_ext_cfg_map.svh"

module pcie_ext_cfg_aer_uncorrectable
   import pcie_ext_cfg_pkg::*;
#(
   parameter int ERR_W = 32  // Width of the error registers
) (
   input wire logic clock,               // 50 MHz clock
   input wire logic arst_n,              // Fundamental reset, async
   input wire logic hotRst_n,            // Non-fundamental reset, sync
   input wire cfg_req_type cfgReq,       // Configuration request
   input wire cfg_id_type ownId,         // Own bus, device, function
   input wire logic [ERR_W-1:0] errEvent, // Error pulses by bit
   input wire nvm_cfg_type nvmCfg,       // Non-volatile settings
   output cfg_rsp_type cfgRsp,           // Completion
   output err_msg_type errMsg,           // Error message requests
   output logic [11:0] serialNextPtr,    // Next pointer for 0x140
   output logic [11:0] hintsNextPtr      // Next pointer for 0x1A0
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rstSync_reg; // Release synchroniser
   logic rstN;              // Synchronised fundamental reset

   // Assert at once, release after two edges
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         rstSync_reg <= 2'b00;
      else
         rstSync_reg <= {rstSync_reg[0], 1'b1};
   end

   assign rstN = rstSync_reg[1];

   // ----------------------------------------
   // Constants
   // ----------------------------------------
   localparam logic [ERR_W-1:0] IMPL = `AER_UNC_IMPL; // Implemented errors
   localparam logic [ERR_W-1:0] SEV_RO = `AER_SEV_RO; // Fixed severity
   localparam logic [ERR_W-1:0] SEV_RST = `AER_SEV_RST; // Severity reset

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   wire [11:0] regOff;      // Byte offset in the 4 KB space
   wire idHit;              // Request routed to this function
   wire reqHit;             // Accepted request
   wire wrAcc;              // Accepted write
   wire selHdr;             // Header dword
   wire selStatus;          // Uncorrectable flags
   wire selMask;            // Uncorrectable mask
   wire selSev;             // Uncorrectable severity
   wire [31:0] beMask;      // Byte enables spread to bits

   // Bits 11:8 extend the legacy 256-byte offset; 31:28 are never read
   assign regOff = {cfgReq.addr[`CFG_REG_MSB:`CFG_REG_LSB], 2'b00};
   assign idHit = (cfgReq.addr[`CFG_BUS_MSB:`CFG_BUS_LSB] == ownId.bus)
      && (cfgReq.addr[`CFG_DEV_MSB:`CFG_DEV_LSB] == ownId.dev)
      && (cfgReq.addr[`CFG_FN_MSB:`CFG_FN_LSB] == ownId.fn);
   // Requests are dropped while a hot reset holds the link
   assign reqHit = cfgReq.valid && idHit && hotRst_n;
   assign wrAcc = reqHit && cfgReq.write;
   assign selHdr = (regOff == `AER_HDR_OFF);
   assign selStatus = (regOff == `AER_STATUS_OFF);
   assign selMask = (regOff == `AER_MASK_OFF);
   assign selSev = (regOff == `AER_SEV_OFF);
   assign beMask = {{8{cfgReq.byteEn[3]}}, {8{cfgReq.byteEn[2]}},
      {8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};

   // ----------------------------------------
   // Write strobes per bit
   // ----------------------------------------
   wire [ERR_W-1:0] flagClr; // Write-one-to-clear strobes
   wire [ERR_W-1:0] maskWe;  // Mask bit write enables
   wire [ERR_W-1:0] sevWe;   // Severity bit write enables

   assign flagClr = (wrAcc && selStatus) ? (cfgReq.data & beMask) : '0;
   assign maskWe = (wrAcc && selMask) ? beMask : '0;
   assign sevWe = (wrAcc && selSev) ? beMask : '0;

   // ----------------------------------------
   // Error bits
   // ----------------------------------------
   logic [ERR_W-1:0] statusVec; // Uncorrectable flags
   logic [ERR_W-1:0] maskVec;   // Uncorrectable mask
   logic [ERR_W-1:0] sevVec;    // Uncorrectable severity

   for (genvar i = 0; i < ERR_W; i++)
   begin : gBit
      if (IMPL[i])
      begin : gImpl
         // Implemented type: sticky flag, mask and severity
         aer_error_bit #(
            .SEV_RESET(SEV_RST[i])
         ) uBit (
            .clock(clock),
            .rst_n(rstN),
            .errEvent(errEvent[i]),
            .clearStrobe(flagClr[i]),
            .maskWe(maskWe[i]),
            .sevWe(sevWe[i]),
            .wrBit(cfgReq.data[i]),
            .statusBit(statusVec[i]),
            .maskBit(maskVec[i]),
            .sevBit(sevVec[i])
         );
      end
      else
      begin : gFixed
         // Unsupported or reserved: flag and mask read zero, severity reads its fixed SEV_RO bit, writes fall away
         assign statusVec[i] = 1'b0;
         assign maskVec[i] = 1'b0;
         assign sevVec[i] = SEV_RO[i];
      end
   end

   // ----------------------------------------
   // Non-volatile capability settings
   // ----------------------------------------
   logic [3:0] aerVer_reg;  // Capability version
   logic serialEn_reg;      // Serial identifier present
   logic hintsEn_reg;       // Processing hints present
   logic latencyEn_reg;     // Latency reporting present

   // Caught from the loader strobe after release, not at reset
   always_ff @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         aerVer_reg <= `AER_VER_RST;
         serialEn_reg <= 1'b1;
         hintsEn_reg <= 1'b1;
         latencyEn_reg <= 1'b1;
      end
      else if (nvmCfg.load)
      begin
         aerVer_reg <= nvmCfg.aerVersion;
         serialEn_reg <= nvmCfg.serialEn;
         hintsEn_reg <= nvmCfg.hintsEn;
         latencyEn_reg <= nvmCfg.latencyEn;
      end
   end

   // ----------------------------------------
   // Capability chain
   // ----------------------------------------
   wire [11:0] hintsNext;   // Behind processing hints
   wire [11:0] serialNext;  // Behind serial identifier
   wire [11:0] aerNext;     // Behind error reporting
   wire [31:0] hdrWord;     // Header dword image

   // Each pointer skips to the next capability still present
   assign hintsNext = latencyEn_reg ? `LATENCY_CAP_OFF : `CHAIN_END_PTR;
   assign serialNext = hintsEn_reg ? `HINTS_CAP_OFF : hintsNext;
   assign aerNext = serialEn_reg ? `SERIAL_CAP_OFF : serialNext;
   assign hdrWord = (32'(aerNext) << `HDR_NEXT_LSB)
      | (32'(aerVer_reg) << `HDR_VER_LSB)
      | (32'(`AER_CAP_ID) << `HDR_ID_LSB);

   logic [11:0] serialNext_reg; // Pointer for the serial block
   logic [11:0] hintsNext_reg;  // Pointer for the hints block

   // Registered so the neighbouring blocks see clean values
   always_ff @(posedge clock or negedge rstN)
   begin
      if (!rstN)
      begin
         serialNext_reg <= `HINTS_CAP_OFF;
         hintsNext_reg <= `LATENCY_CAP_OFF;
      end
      else
      begin
         serialNext_reg <= serialNext;
         hintsNext_reg <= hintsNext;
      end
   end

   assign serialNextPtr = serialNext_reg;
   assign hintsNextPtr = hintsNext_reg;

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   wire [31:0] rdMux; // Selected read data
   // Other offsets of the 4 KB space read zero here
   assign rdMux = selHdr ? hdrWord
      : selStatus ? 32'(statusVec)
      : selMask ? 32'(maskVec)
      : selSev ? 32'(sevVec)
      : 32'h00000000;

   cfg_rsp_type rsp_reg;  // Completion register
   cfg_rsp_type rsp_next; // Its next value

   assign rsp_next.valid = reqHit;
   assign rsp_next.data = (reqHit && !cfgReq.write) ? rdMux : 32'h00000000;

   // Non-sticky: hot reset clears it as well
   always_ff @(posedge clock or negedge rstN)
   begin
      if (!rstN)
         rsp_reg <= '0;
      else if (!hotRst_n)
         rsp_reg <= '0;
      else
         rsp_reg <= rsp_next;
   end

   assign cfgRsp = rsp_reg;

   // ----------------------------------------
   // Error messages
   // ----------------------------------------
   wire [ERR_W-1:0] reportable; // Unmasked implemented errors
   err_msg_type msg_reg;        // Message request register
   err_msg_type msg_next;       // Its next value

   // The mask gates only the message; the flag is set regardless
   assign reportable = errEvent & IMPL & ~maskVec;
   assign msg_next.fatal = |(reportable & sevVec);
   assign msg_next.nonFatal = |(reportable & ~sevVec);

   always_ff @(posedge clock or negedge rstN)
   begin
      if (!rstN)
         msg_reg <= '0;
      else if (!hotRst_n)
         msg_reg <= '0;
      else
         msg_reg <= msg_next;
   end

   assign errMsg = msg_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   // Checks stay quiet while the synchronised reset is low, so the two
   // release edges never judge a half-reset state
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstN);

   flag_set_a: assert property ((|(errEvent & IMPL)) |=>
      ((statusVec & $past(errEvent & IMPL)) == $past(errEvent & IMPL)))
      else $error("error event did not set its flag");

   flag_clear_a: assert property ((flagClr[4] && !errEvent[4]) |=>
      !statusVec[4])
      else $error("write one did not clear the flag");

   set_wins_a: assert property ((|(flagClr & errEvent & IMPL)) |=>
      ((statusVec & $past(flagClr & errEvent & IMPL))
      == $past(flagClr & errEvent & IMPL)))
      else $error("clear beat a simultaneous error");

   status_ro_a: assert property ((statusVec & ~IMPL) == '0)
      else $error("unsupported flag reads nonzero");

   mask_ro_a: assert property ((maskVec & ~IMPL) == '0)
      else $error("unsupported mask bit reads nonzero");

   // A full-dword mask write lands only on the implemented bits
   mask_write_a: assert property ((wrAcc && selMask && cfgReq.byteEn == 4'hF) |=>
      (maskVec == ($past(cfgReq.data) & IMPL)))
      else $error("mask write landed wrong");

   hdr_read_a: assert property ((reqHit && !cfgReq.write && selHdr) |=>
      (cfgRsp.valid && cfgRsp.data[15:0] == `AER_CAP_ID
      && cfgRsp.data[31:20] == $past(aerNext)))
      else $error("header dword read wrong");

   ver_load_a: assert property (nvmCfg.load |=>
      (aerVer_reg == $past(nvmCfg.aerVersion)))
      else $error("version not taken from the loader");

   ext_read_a: assert property ((reqHit && !cfgReq.write && selStatus) |=>
      (cfgRsp.valid && cfgRsp.data == 32'($past(statusVec))))
      else $error("flag register read wrong");

   // A request for another function must not be answered here
   id_miss_a: assert property ((cfgReq.valid && !idHit) |=>
      !cfgRsp.valid)
      else $error("completion sent for another function");

   masked_quiet_a: assert property (((errEvent & IMPL & ~maskVec) == '0) |=>
      (!errMsg.fatal && !errMsg.nonFatal))
      else $error("message sent for a masked error");

   // Hot reset drops messages, so only a running link is held to them
   fatal_msg_a: assert property ((hotRst_n && |(errEvent & IMPL & ~maskVec & sevVec)) |=>
      errMsg.fatal)
      else $error("fatal error not reported");

   nonfatal_msg_a: assert property ((hotRst_n && |(errEvent & IMPL & ~maskVec & ~sevVec)) |=>
      errMsg.nonFatal)
      else $error("non-fatal error not reported");

   chain_skip_a: assert property (!serialEn_reg |->
      (aerNext != `SERIAL_CAP_OFF))
      else $error("disabled capability left in chain");

   sticky_keep_a: assert property ((!hotRst_n && errEvent == '0) |=>
      (statusVec == $past(statusVec) && maskVec == $past(maskVec)))
      else $error("hot reset disturbed sticky bits");

   flag_cleared_c: cover property (statusVec[12] ##1 !statusVec[12]);
   fatal_sent_c: cover property (errMsg.fatal);
   nonfatal_sent_c: cover property (errMsg.nonFatal);
   skip_read_c: cover property (!serialEn_reg && reqHit && selHdr);
   hot_refused_c: cover property (cfgReq.valid && idHit && !hotRst_n);

endmodule

`default_nettype wire

// File: sim/cfg_host_model.sv
/*
   Behavioural host that issues configuration requests to the block.
   Assumes completions are registered on the taking edge and stand for one cycle.
*/
`timescale 1ns/10ps
`default_nettype none

module cfg_host_model
   import pcie_ext_cfg_pkg::*;
(
   input wire logic clock,         // Bench clock
   input wire cfg_id_type ownId,   // Identity of the target
   input wire cfg_rsp_type cfgRsp, // Completion from the block
   output cfg_req_type cfgReq      // Request toward the block
);
   // ----------------------------------------
   // Idle request at time zero
   // ----------------------------------------
   initial
   begin
      cfgReq = '0;
   end

   // One dword access; foreign flips the device number so the id misses
   task automatic cfg_access(input logic wr, input logic [11:0] off, input logic foreign,
      input logic [31:0] wdata, input logic [3:0] be, output logic [31:0] rdata,
      output logic gotRsp);
      @(negedge clock);
      cfgReq.valid = 1'b1;
      cfgReq.write = wr;
      cfgReq.addr = {4'h0, ownId.bus, ownId.dev ^ {4'h0, foreign}, ownId.fn, off[11:2], 2'b00};
      cfgReq.data = wdata;
      cfgReq.byteEn = be;
      @(negedge clock);
      // Completion stands for one cycle only, so take it before releasing
      gotRsp = cfgRsp.valid;
      rdata = cfgRsp.data;
      cfgReq.valid = 1'b0;
      // Released address and data show the inverse so stale values cannot be reused
      cfgReq.addr = ~cfgReq.addr;
      cfgReq.data = ~cfgReq.data;
   endtask
endmodule

`default_nettype wire

// File: sim/pcie_ext_cfg_aer_uncorrectable_bench.sv
/*
   Self-checking bench for the extended configuration register logic.
   Assumes the host model is the only source of configuration requests.
*/
`timescale 1ns/10ps
`default_nettype none

module pcie_ext_cfg_aer_uncorrectable_bench
   import pcie_ext_cfg_pkg::*;
;
   // ----------------------------------------
   // Stimulus and observation signals
   // ----------------------------------------
   logic clock = 1'b0; // 50 MHz
   logic arst_n = 1'b0; // Fundamental reset
   logic hotRst_n = 1'b1; // Hot reset
   cfg_req_type cfgReq; // Driven by the host model
   cfg_id_type ownId = '{8'h3A, 5'h07, 3'h2}; // Own identity
   logic [31:0] errEvent = '0; // Error pulses
   nvm_cfg_type nvmCfg = '{1'b0, 4'h2, 1'b1, 1'b1, 1'b1}; // Loader values
   cfg_rsp_type cfgRsp; // Completion
   err_msg_type errMsg; // Error messages
   logic [11:0] serialNextPtr; // Pointer out of 0x140
   logic [11:0] hintsNextPtr; // Pointer out of 0x1A0
   int nErrors = 0; // Mismatches
   int numChecks = 0; // Comparisons

   pcie_ext_cfg_aer_uncorrectable pcie_ext_cfg_aer_uncorrectable_i (
      .clock(clock), .arst_n(arst_n), .hotRst_n(hotRst_n), .cfgReq(cfgReq), .ownId(ownId),
      .errEvent(errEvent), .nvmCfg(nvmCfg), .cfgRsp(cfgRsp), .errMsg(errMsg),
      .serialNextPtr(serialNextPtr), .hintsNextPtr(hintsNextPtr)
   );

   cfg_host_model cfg_host_model_i (
      .clock(clock), .ownId(ownId), .cfgRsp(cfgRsp), .cfgReq(cfgReq)
   );

   // Free-running clock
   initial
   begin
      forever #10 clock = ~clock;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks=%0d errors=%0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp)
      begin
         nErrors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Read and compare; expGot low means no completion is allowed
   task automatic rd(input logic [11:0] off, input logic foreign, input logic expGot,
      input logic [31:0] exp);
      logic [31:0] d;
      logic g;
      cfg_host_model_i.cfg_access(1'b0, off, foreign, 32'h0, 4'hF, d, g);
      check32({31'h0, g}, {31'h0, expGot});
      if (expGot)
         check32(d, exp);
   endtask

   // Write; completion carries zero data
   task automatic wr(input logic [11:0] off, input logic [31:0] data, input logic [3:0] be);
      logic [31:0] d;
      logic g;
      cfg_host_model_i.cfg_access(1'b1, off, 1'b0, data, be, d, g);
      check32({31'h0, g}, 32'h1);
      check32(d, 32'h0);
   endtask

   // One-cycle error pulse; message shows one cycle later
   task automatic pulse(input logic [31:0] vec, input logic [1:0] expMsg);
      @(negedge clock);
      errEvent = vec;
      @(negedge clock);
      errEvent = '0;
      check32({30'h0, errMsg}, {30'h0, expMsg});
   endtask

   task automatic nvm_load(input logic [3:0] ver, input logic s, input logic h, input logic l);
      @(negedge clock);
      nvmCfg = '{1'b1, ver, s, h, l};
      @(negedge clock);
      nvmCfg.load = 1'b0;
      repeat (2) @(negedge clock);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_defaults();
      rd(12'h100, 1'b0, 1'b1, 32'h14020001);
      rd(12'h104, 1'b0, 1'b1, 32'h0);
      rd(12'h108, 1'b0, 1'b1, 32'h0);
      rd(12'h10C, 1'b0, 1'b1, 32'h00462031);
      check32({20'h0, serialNextPtr}, 32'h1A0);
      check32({20'h0, hintsNextPtr}, 32'h1C0);
      wr(12'h100, 32'hFFFFFFFF, 4'hF);
      rd(12'h100, 1'b0, 1'b1, 32'h14020001);
      rd(12'h008, 1'b0, 1'b1, 32'h0);
      rd(12'h204, 1'b0, 1'b1, 32'h0);
      $display("test_defaults done");
   endtask

   task automatic test_mask();
      wr(12'h108, 32'hFFFFFFFF, 4'h2);
      rd(12'h108, 1'b0, 1'b1, 32'h0000F000);
      wr(12'h108, 32'hFFFFFFFF, 4'hF);
      rd(12'h108, 1'b0, 1'b1, 32'h001FF010);
      wr(12'h108, 32'h0, 4'hF);
      $display("test_mask done");
   endtask

   task automatic test_status();
      pulse(32'hFFFFFFFF, 2'b11);
      rd(12'h104, 1'b0, 1'b1, 32'h001FF010);
      wr(12'h104, 32'h00001000, 4'hF);
      rd(12'h104, 1'b0, 1'b1, 32'h001FE010);
      wr(12'h104, 32'hFFFFFFFF, 4'hF);
      rd(12'h104, 1'b0, 1'b1, 32'h0);
      $display("test_status done");
   endtask

   task automatic test_masked();
      wr(12'h108, 32'h00001000, 4'hF);
      pulse(32'h00001000, 2'b00);
      rd(12'h104, 1'b0, 1'b1, 32'h00001000);
      pulse(32'h00002000, 2'b10);
      pulse(32'h00004000, 2'b01);
      wr(12'h108, 32'h0, 4'hF);
      // Severity raised: the poisoned-packet error now goes out as fatal
      wr(12'h10C, 32'hFFFFFFFF, 4'hF);
      rd(12'h10C, 1'b0, 1'b1, 32'h005FF031);
      pulse(32'h00001000, 2'b10);
      wr(12'h10C, 32'h00062010, 4'hF);
      rd(12'h10C, 1'b0, 1'b1, 32'h00462031);
      wr(12'h104, 32'hFFFFFFFF, 4'hF);
      $display("test_masked done");
   endtask

   // Clear write and a new error meet at the same edge
   task automatic test_race();
      logic [31:0] d;
      logic g;
      pulse(32'h00008000, 2'b01);
      fork
         cfg_host_model_i.cfg_access(1'b1, 12'h104, 1'b0, 32'h00008000, 4'hF, d, g);
         begin
            @(negedge clock);
            errEvent = 32'h00008000;
            @(negedge clock);
            errEvent = '0;
         end
      join
      rd(12'h104, 1'b0, 1'b1, 32'h00008000);
      wr(12'h104, 32'hFFFFFFFF, 4'hF);
      rd(12'h104, 1'b1, 1'b0, 32'h0);
      $display("test_race done");
   endtask

   task automatic test_resets();
      wr(12'h108, 32'h00010000, 4'hF);
      pulse(32'h00010000, 2'b00);
      @(negedge clock);
      hotRst_n = 1'b0;
      repeat (2) @(negedge clock);
      rd(12'h104, 1'b0, 1'b0, 32'h0);
      hotRst_n = 1'b1;
      rd(12'h104, 1'b0, 1'b1, 32'h00010000);
      rd(12'h108, 1'b0, 1'b1, 32'h00010000);
      arst_n = 1'b0;
      repeat (3) @(negedge clock);
      arst_n = 1'b1;
      repeat (3) @(negedge clock);
      rd(12'h104, 1'b0, 1'b1, 32'h0);
      rd(12'h108, 1'b0, 1'b1, 32'h0);
      $display("test_resets done");
   endtask

   task automatic test_nvm();
      nvm_load(4'h5, 1'b0, 1'b1, 1'b1);
      rd(12'h100, 1'b0, 1'b1, 32'h1A050001);
      nvm_load(4'h2, 1'b1, 1'b0, 1'b0);
      rd(12'h100, 1'b0, 1'b1, 32'h14020001);
      check32({20'h0, serialNextPtr}, 32'h000);
      check32({20'h0, hintsNextPtr}, 32'h000);
      nvm_load(4'h2, 1'b0, 1'b0, 1'b0);
      rd(12'h100, 1'b0, 1'b1, 32'h00020001);
      nvm_load(4'h2, 1'b1, 1'b1, 1'b1);
      check32({20'h0, serialNextPtr}, 32'h1A0);
      check32({20'h0, hintsNextPtr}, 32'h1C0);
      $display("test_nvm done");
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20) @(negedge clock);
      arst_n = 1'b1;
      repeat (3) @(negedge clock);
      test_defaults();
      test_mask();
      test_status();
      test_masked();
      test_race();
      test_resets();
      test_nvm();
      report_and_stop();
   end

   // Cuts a hang short well inside the cycle budget
   initial
   begin
      #1000000;
      nErrors++;
      report_and_stop();
   end
endmodule

`default_nettype wire
